// [design/usb_bridge_pkg.sv]
package usb_bridge_pkg;

	// setup stage that delivers a command
	localparam logic [7:0]  SETUP_TYPE     = 8'h21;
	localparam logic [7:0]  SETUP_REQUEST  = 8'h09;
	localparam logic [15:0] SETUP_INDEX    = 16'h0003;

	// byte 0 operation and interface codes
	localparam logic [7:0] OP_WRITE      = 8'h10;
	localparam logic [7:0] IF_GPIO       = 8'h08;
	localparam logic [7:0] IF_SPI16      = 8'h04;
	localparam logic [7:0] IF_I2C_FAST   = 8'h02;
	localparam logic [7:0] IF_I2C_100K   = 8'h01;
	localparam logic [7:0] IF_SPI8       = 8'h00;
	localparam logic [7:0] IF_FIELD_MASK = 8'h0F;
	localparam logic [7:0] RSVD_MASK     = 8'hE0;

	// status flags ORed into response byte 0
	localparam logic [7:0] REQ_ERROR_FLAG   = 8'h80;
	localparam logic [7:0] BUS_FAILURE_FLAG = 8'h40;
	localparam logic [7:0] REQ_DONE_FLAG    = 8'h20;

	// packet byte positions
	localparam logic [5:0] BYTE_CMD    = 6'h00;
	localparam logic [5:0] BYTE_TARGET = 6'h01;
	localparam logic [5:0] BYTE_LEN    = 6'h02;
	localparam logic [5:0] BYTE_REG    = 6'h03;
	localparam logic [5:0] BYTE_DATA   = 6'h04;

	// packet limits
	localparam int         MEM_DEPTH    = 64;
	localparam logic [6:0] MEM_LIMIT    = 7'h40;
	localparam logic [7:0] MAX_DATA     = 8'h3C;
	localparam logic [7:0] GPIO_LEN     = 8'h01;
	localparam logic [7:0] I2C_RD_BIT   = 8'h01;
	localparam logic [7:0] I2C_FILL     = 8'hFF;
	localparam logic [7:0] SPI_FILL     = 8'h00;
	localparam logic [3:0] I2C_LAST_BIT = 4'h8;
	localparam logic [3:0] SPI_LAST_BIT = 4'h7;

	// serial clock rates, each bit split into four quarters
	localparam int CLK_PERIOD_PS     = 4000;
	localparam int I2C_100K_RATE_KHZ = 100;
	localparam int I2C_FAST_RATE_KHZ = 400;
	localparam int SPI_RATE_KHZ      = 1000;
	localparam int PS_PER_KHZ        = 1000000000;
	localparam logic [9:0] Q_I2C_100K = 10'((PS_PER_KHZ / (4 * I2C_100K_RATE_KHZ) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [9:0] Q_I2C_FAST = 10'((PS_PER_KHZ / (4 * I2C_FAST_RATE_KHZ) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [9:0] Q_SPI      = 10'((PS_PER_KHZ / (4 * SPI_RATE_KHZ) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	// command sequencer states
	typedef enum logic [3:0]
	{
		S_IDLE   = 4'h0,
		S_DECODE = 4'h1,
		S_GPIO   = 4'h2,
		S_GPIOW  = 4'h3,
		S_START  = 4'h4,
		S_FETCH  = 4'h5,
		S_LOAD   = 4'h6,
		S_BIT    = 4'h7,
		S_STORE  = 4'h8,
		S_STOP   = 4'h9,
		S_FIN    = 4'hA,
		S_RREQ   = 4'hB,
		S_RSPV   = 4'hC
	} state_t;

endpackage : usb_bridge_pkg

// [design/packet_ram.sv]
`timescale 1ns/100ps
module packet_ram
(
	// clock
	input  wire logic       clk,
	// single port
	input  wire logic       we,
	input  wire logic [5:0] addr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata
);

	logic [7:0] store [usb_bridge_pkg::MEM_DEPTH];

	// registered read, old word returned on a same-address write
	always_ff @(posedge clk)
	begin
		if (we)
			store[addr] <= wdata;
		rdata <= store[addr];
	end

endmodule : packet_ram

// [design/usb_bridge_cmd.sv]
`timescale 1ns/100ps
module usb_bridge_cmd
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// setup stage of the control request
	input  wire logic        setupValid,
	input  wire logic [7:0]  setupType,
	input  wire logic [7:0]  setupRequest,
	input  wire logic [15:0] setupIndex,
	// request data bytes
	input  wire logic        reqValid,
	input  wire logic [7:0]  reqData,
	input  wire logic        reqLast,
	output logic             reqReady,
	// interrupt response bytes
	output logic             rspValid,
	output logic      [7:0]  rspData,
	output logic             rspLast,
	input  wire logic        rspReady,
	// i2c open-drain lines
	input  wire logic        sclIn,
	output logic             sclOut,
	output logic             sclOe,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	// spi lines
	output logic             spiClk,
	output logic             spiMosi,
	input  wire logic        spiMiso,
	output logic             spiCsN,
	// gpio lines, bit n is gpio_line_n
	input  wire logic [6:0]  gpioLineIn,
	output logic      [6:0]  gpioLineOut,
	// status
	output logic             busy
);

	// decoding helpers
	function automatic logic ifaceIsI2c(input logic [7:0] cmd);
		logic [7:0] f;
		f = cmd & usb_bridge_pkg::IF_FIELD_MASK;
		ifaceIsI2c = (f == usb_bridge_pkg::IF_I2C_100K) || (f == usb_bridge_pkg::IF_I2C_FAST);
	endfunction : ifaceIsI2c

	function automatic logic cmdIsValid(input logic [7:0] cmd);
		logic [7:0] f;
		f = cmd & usb_bridge_pkg::IF_FIELD_MASK;
		cmdIsValid = ((cmd & usb_bridge_pkg::RSVD_MASK) == 8'h00) &&
			(f == usb_bridge_pkg::IF_GPIO || f == usb_bridge_pkg::IF_SPI16 ||
			ifaceIsI2c(cmd) || f == usb_bridge_pkg::IF_SPI8);
	endfunction : cmdIsValid

	usb_bridge_pkg::state_t stateFf;
	logic        armedFf;
	logic [6:0]  rxCntFf;
	logic [7:0]  cmdFf;
	logic [7:0]  lenFf;
	logic        reqErrFf;
	logic        failFf;
	logic [6:0]  stepFf;
	logic [1:0]  qFf;
	logic [9:0]  divFf;
	logic [3:0]  bitFf;
	logic [7:0]  txFf;
	logic [7:0]  rxFf;
	logic        ackBadFf;
	logic [6:0]  ptrFf;
	logic [6:0]  respLenFf;
	logic        i2cActFf;
	logic        csActFf;
	logic        sclLowFf;
	logic        sdaLowFf;
	logic        spiClkFf;
	logic        mosiFf;
	logic [6:0]  gpioOutFf;
	logic [9:0]  syncAFf;
	logic [9:0]  syncBFf;
	logic        nxt_sclLow;
	logic        nxt_sdaLow;
	logic        nxt_spiClk;
	logic        memWe;
	logic [5:0]  memAddr;
	logic [7:0]  memWdata;
	logic [7:0]  memRdata;

	// two-flop synchronisers for pin inputs
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			syncAFf <= 10'h3FF;
			syncBFf <= 10'h3FF;
		end
		else
		begin
			syncAFf <= {sclIn, sdaIn, spiMiso, gpioLineIn};
			syncBFf <= syncAFf;
		end
	end

	logic       sclSync;
	logic       sdaSync;
	logic       misoSync;
	logic [6:0] gpioSync;
	assign sclSync  = syncBFf[9];
	assign sdaSync  = syncBFf[8];
	assign misoSync = syncBFf[7];
	assign gpioSync = syncBFf[6:0];

	// command field decode
	logic       isI2c;
	logic       isGpio;
	logic       isSpi16;
	logic       isRead;
	logic       reqErrNow;
	logic [6:0] dataStart;
	logic [6:0] totalSteps;
	logic       dataStep;
	logic       rxStep;
	logic       lastStep;
	logic       storeEn;
	logic [5:0] fetchAddr;
	logic [7:0] txByte;
	logic [3:0] lastBit;
	logic [9:0] quarter;
	logic       timed;
	logic       stall;
	logic       tick;
	logic       rxFire;
	logic       bitLow;
	logic [7:0] status;

	assign isI2c   = ifaceIsI2c(cmdFf);
	assign isGpio  = (cmdFf & usb_bridge_pkg::IF_FIELD_MASK) == usb_bridge_pkg::IF_GPIO;
	assign isSpi16 = (cmdFf & usb_bridge_pkg::IF_FIELD_MASK) == usb_bridge_pkg::IF_SPI16;
	assign isRead  = (cmdFf & usb_bridge_pkg::OP_WRITE) == 8'h00;
	assign reqErrNow = !cmdIsValid(cmdFf) || (lenFf > usb_bridge_pkg::MAX_DATA) ||
		(isGpio && lenFf != usb_bridge_pkg::GPIO_LEN);

	// byte sequence: header bytes, then data bytes
	assign dataStart  = isI2c ? (isRead ? 7'h3 : 7'h2) : (isSpi16 ? 7'h2 : 7'h1);
	assign totalSteps = dataStart + lenFf[6:0];
	assign dataStep   = stepFf >= dataStart;
	assign rxStep     = isI2c && isRead && dataStep;
	assign lastStep   = stepFf == totalSteps - 7'h1;
	assign storeEn    = isI2c ? rxStep : (!dataStep || isRead);
	assign fetchAddr  = dataStep ? usb_bridge_pkg::BYTE_DATA + 6'(stepFf - dataStart) :
		(((isI2c || isSpi16) ? (stepFf == 7'h1) : 1'b1) ? usb_bridge_pkg::BYTE_REG
		: usb_bridge_pkg::BYTE_TARGET);

	// byte to shift out for the current step
	always_comb
	begin
		txByte = memRdata;
		if (isI2c)
		begin
			if (stepFf == 7'h0)
				txByte = memRdata & ~usb_bridge_pkg::I2C_RD_BIT;
			else if (rxStep)
				txByte = usb_bridge_pkg::I2C_FILL;
			else if (isRead && stepFf == 7'h2)
				txByte = memRdata | usb_bridge_pkg::I2C_RD_BIT;
		end
		else if (dataStep && isRead)
			txByte = usb_bridge_pkg::SPI_FILL;
	end

	// quarter-bit timing with clock stretching
	assign lastBit = isI2c ? usb_bridge_pkg::I2C_LAST_BIT : usb_bridge_pkg::SPI_LAST_BIT;
	assign quarter = !isI2c ? usb_bridge_pkg::Q_SPI :
		((cmdFf & usb_bridge_pkg::IF_FIELD_MASK) == usb_bridge_pkg::IF_I2C_100K ?
		usb_bridge_pkg::Q_I2C_100K : usb_bridge_pkg::Q_I2C_FAST);
	assign timed  = stateFf == usb_bridge_pkg::S_START || stateFf == usb_bridge_pkg::S_BIT ||
		stateFf == usb_bridge_pkg::S_STOP;
	assign stall  = i2cActFf && !sclLowFf && !sclSync;
	assign tick   = timed && divFf == quarter - 10'h1 && !stall;
	assign rxFire = reqValid && armedFf;
	assign bitLow = (bitFf < usb_bridge_pkg::I2C_LAST_BIT) ? !txFf[7] : (rxStep && !lastStep);
	assign status = reqErrFf ? usb_bridge_pkg::REQ_ERROR_FLAG :
		(failFf ? usb_bridge_pkg::BUS_FAILURE_FLAG : usb_bridge_pkg::REQ_DONE_FLAG);

	// packet memory port steering
	always_comb
	begin
		memWe    = 1'b0;
		memAddr  = ptrFf[5:0];
		memWdata = reqData;
		case (stateFf)
			usb_bridge_pkg::S_IDLE:
			begin
				memWe   = rxFire && rxCntFf < usb_bridge_pkg::MEM_LIMIT;
				memAddr = rxCntFf[5:0];
			end
			usb_bridge_pkg::S_FETCH: memAddr = fetchAddr;
			usb_bridge_pkg::S_STORE:
			begin
				memWe    = storeEn;
				memAddr  = fetchAddr;
				memWdata = rxFf;
			end
			usb_bridge_pkg::S_GPIO: memAddr = usb_bridge_pkg::BYTE_DATA;
			usb_bridge_pkg::S_GPIOW:
			begin
				memWe    = isRead;
				memAddr  = usb_bridge_pkg::BYTE_DATA;
				memWdata = {1'b0, gpioSync};
			end
			usb_bridge_pkg::S_FIN:
			begin
				memWe    = 1'b1;
				memAddr  = usb_bridge_pkg::BYTE_CMD;
				memWdata = cmdFf | status;
			end
			default: memAddr = ptrFf[5:0];
		endcase
	end

	packet_ram ram
	(
		.clk   (clk),
		.we    (memWe),
		.addr  (memAddr),
		.wdata (memWdata),
		.rdata (memRdata)
	);

	// command sequencer
	always_ff @(posedge clk)
	begin
		if (rst)
			stateFf <= usb_bridge_pkg::S_IDLE;
		else
		begin
			case (stateFf)
				usb_bridge_pkg::S_IDLE:
					if (rxFire && reqLast)
						stateFf <= usb_bridge_pkg::S_DECODE;
				usb_bridge_pkg::S_DECODE:
					if (reqErrNow)
						stateFf <= usb_bridge_pkg::S_FIN;
					else if (isGpio)
						stateFf <= usb_bridge_pkg::S_GPIO;
					else if (isI2c)
						stateFf <= usb_bridge_pkg::S_START;
					else
						stateFf <= usb_bridge_pkg::S_FETCH;
				usb_bridge_pkg::S_GPIO:  stateFf <= usb_bridge_pkg::S_GPIOW;
				usb_bridge_pkg::S_GPIOW: stateFf <= usb_bridge_pkg::S_FIN;
				usb_bridge_pkg::S_START:
					if (tick && qFf == 2'h3)
						stateFf <= usb_bridge_pkg::S_FETCH;
				usb_bridge_pkg::S_FETCH: stateFf <= usb_bridge_pkg::S_LOAD;
				usb_bridge_pkg::S_LOAD:  stateFf <= usb_bridge_pkg::S_BIT;
				usb_bridge_pkg::S_BIT:
					if (tick && qFf == 2'h3 && bitFf == lastBit)
						stateFf <= usb_bridge_pkg::S_STORE;
				usb_bridge_pkg::S_STORE:
					if (ackBadFf || lastStep)
						stateFf <= isI2c ? usb_bridge_pkg::S_STOP : usb_bridge_pkg::S_FIN;
					else if (isI2c && isRead && stepFf == 7'h1)
						stateFf <= usb_bridge_pkg::S_START;
					else
						stateFf <= usb_bridge_pkg::S_FETCH;
				usb_bridge_pkg::S_STOP:
					if (tick && qFf == 2'h3)
						stateFf <= usb_bridge_pkg::S_FIN;
				usb_bridge_pkg::S_FIN:  stateFf <= usb_bridge_pkg::S_RREQ;
				usb_bridge_pkg::S_RREQ: stateFf <= usb_bridge_pkg::S_RSPV;
				usb_bridge_pkg::S_RSPV:
					if (rspReady)
						stateFf <= rspLast ? usb_bridge_pkg::S_IDLE : usb_bridge_pkg::S_RREQ;
				default: stateFf <= usb_bridge_pkg::S_IDLE;
			endcase
		end
	end

	// request intake after a matching setup stage
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			armedFf <= 1'b0;
			rxCntFf <= 7'h0;
			cmdFf   <= 8'h00;
			lenFf   <= 8'h00;
		end
		else if (stateFf == usb_bridge_pkg::S_IDLE)
		begin
			if (setupValid && !armedFf && setupType == usb_bridge_pkg::SETUP_TYPE &&
				setupRequest == usb_bridge_pkg::SETUP_REQUEST && setupIndex == usb_bridge_pkg::SETUP_INDEX)
			begin
				armedFf <= 1'b1;
				rxCntFf <= 7'h0;
			end
			else if (rxFire)
			begin
				if (rxCntFf == 7'h0)
					cmdFf <= reqData;
				if (rxCntFf == 7'h2)
					lenFf <= reqData;
				if (rxCntFf < usb_bridge_pkg::MEM_LIMIT)
					rxCntFf <= rxCntFf + 7'h1;
				if (reqLast)
					armedFf <= 1'b0;
			end
		end
	end

	// transaction bookkeeping
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reqErrFf  <= 1'b0;
			failFf    <= 1'b0;
			stepFf    <= 7'h0;
			respLenFf <= 7'h0;
			ptrFf     <= 7'h0;
		end
		else
		begin
			if (stateFf == usb_bridge_pkg::S_DECODE)
			begin
				reqErrFf  <= reqErrNow;
				failFf    <= 1'b0;
				stepFf    <= 7'h0;
				respLenFf <= reqErrNow ? rxCntFf : 7'(6'(usb_bridge_pkg::BYTE_DATA) + lenFf[6:0]);
			end
			if (stateFf == usb_bridge_pkg::S_STORE)
			begin
				stepFf <= stepFf + 7'h1;
				if (ackBadFf)
					failFf <= 1'b1;
			end
			if (stateFf == usb_bridge_pkg::S_FIN)
				ptrFf <= 7'h0;
			else if (stateFf == usb_bridge_pkg::S_RSPV && rspReady)
				ptrFf <= ptrFf + 7'h1;
		end
	end

	// bit engine: divider, quarters, shifters
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			divFf    <= 10'h0;
			qFf      <= 2'h0;
			bitFf    <= 4'h0;
			txFf     <= 8'h00;
			rxFf     <= 8'h00;
			ackBadFf <= 1'b0;
		end
		else
		begin
			if (!timed || tick)
				divFf <= 10'h0;
			else if (!stall)
				divFf <= divFf + 10'h1;
			if (!timed)
				qFf <= 2'h0;
			else if (tick)
				qFf <= qFf + 2'h1;
			if (stateFf == usb_bridge_pkg::S_LOAD)
			begin
				bitFf    <= 4'h0;
				txFf     <= txByte;
				ackBadFf <= 1'b0;
			end
			else if (stateFf == usb_bridge_pkg::S_BIT && tick)
			begin
				if (qFf == 2'h2 && bitFf < usb_bridge_pkg::I2C_LAST_BIT)
					rxFf <= {rxFf[6:0], isI2c ? sdaSync : misoSync};
				if (qFf == 2'h2 && bitFf == usb_bridge_pkg::I2C_LAST_BIT && !rxStep)
					ackBadFf <= sdaSync;
				if (qFf == 2'h3)
				begin
					bitFf <= bitFf + 4'h1;
					txFf  <= {txFf[6:0], 1'b0};
				end
			end
		end
	end

	// next line levels per quarter, clock held low between bytes but not after stop
	always_comb
	begin
		nxt_sclLow = i2cActFf && stateFf != usb_bridge_pkg::S_FIN;
		nxt_sdaLow = 1'b0;
		nxt_spiClk = 1'b0;
		case (stateFf)
			usb_bridge_pkg::S_START:
			begin
				nxt_sclLow = qFf == 2'h0 || qFf == 2'h3;
				nxt_sdaLow = qFf[1];
			end
			usb_bridge_pkg::S_BIT:
				if (isI2c)
				begin
					nxt_sclLow = qFf == 2'h0 || qFf == 2'h3;
					nxt_sdaLow = bitLow;
				end
				else
					nxt_spiClk = qFf == 2'h1 || qFf == 2'h2;
			usb_bridge_pkg::S_STOP:
			begin
				nxt_sclLow = qFf == 2'h0;
				nxt_sdaLow = !qFf[1];
			end
			default: nxt_sdaLow = 1'b0;
		endcase
	end

	// registered serial and gpio outputs
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			i2cActFf  <= 1'b0;
			csActFf   <= 1'b0;
			sclLowFf  <= 1'b0;
			sdaLowFf  <= 1'b0;
			spiClkFf  <= 1'b0;
			mosiFf    <= 1'b0;
			gpioOutFf <= 7'h00;
		end
		else
		begin
			sclLowFf <= nxt_sclLow;
			sdaLowFf <= nxt_sdaLow;
			spiClkFf <= nxt_spiClk;
			mosiFf   <= (stateFf == usb_bridge_pkg::S_BIT) && txFf[7];
			if (stateFf == usb_bridge_pkg::S_START)
				i2cActFf <= 1'b1;
			else if (stateFf == usb_bridge_pkg::S_FIN)
				i2cActFf <= 1'b0;
			if (stateFf == usb_bridge_pkg::S_DECODE && !reqErrNow && !isGpio && !isI2c)
				csActFf <= 1'b1;
			else if (stateFf == usb_bridge_pkg::S_FIN)
				csActFf <= 1'b0;
			if (stateFf == usb_bridge_pkg::S_GPIOW && !isRead)
				gpioOutFf <= memRdata[6:0];
		end
	end

	// port assignments
	assign reqReady    = armedFf;
	assign rspValid    = stateFf == usb_bridge_pkg::S_RSPV;
	assign rspData     = memRdata;
	assign rspLast     = rspValid && ptrFf == respLenFf - 7'h1;
	assign sclOut      = 1'b0;
	assign sdaOut      = 1'b0;
	assign sclOe       = sclLowFf;
	assign sdaOe       = sdaLowFf;
	assign spiClk      = spiClkFf;
	assign spiMosi     = mosiFf;
	assign spiCsN      = !csActFf;
	assign gpioLineOut = gpioOutFf;
	assign busy        = stateFf != usb_bridge_pkg::S_IDLE;

endmodule : usb_bridge_cmd

// [tb/usb_bridge_cmd_asserts.sv]
`timescale 1ns/100ps
module usb_bridge_cmd_asserts
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// host side
	input wire logic        setupValid,
	input wire logic [7:0]  setupType,
	input wire logic [7:0]  setupRequest,
	input wire logic [15:0] setupIndex,
	input wire logic        reqValid,
	input wire logic        reqLast,
	input wire logic        reqReady,
	input wire logic        rspValid,
	input wire logic [7:0]  rspData,
	input wire logic        rspReady,
	// far side and status
	input wire logic        sclOe,
	input wire logic        sdaOe,
	input wire logic        spiClk,
	input wire logic        spiCsN,
	input wire logic [6:0]  gpioLineOut,
	input wire logic        busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic       setupOk;
	logic       sclOeQ_ff;
	logic [9:0] sclGap_ff;
	// setup stage that carries a command
	assign setupOk = setupValid && setupType == usb_bridge_pkg::SETUP_TYPE
		&& setupRequest == usb_bridge_pkg::SETUP_REQUEST && setupIndex == usb_bridge_pkg::SETUP_INDEX;
	// cycles since the clock line last moved
	always_ff @(posedge clk)
	begin
		sclOeQ_ff <= sclOe;
		sclGap_ff <= (rst || sclOe != sclOeQ_ff) ? 10'h000 : sclGap_ff + {9'h000, sclGap_ff != 10'h3FF};
	end
	AST_ARM: assert property (setupOk && !busy && !reqReady |=> reqReady)
		else $error("command setup did not arm the stream");
	AST_NO_ARM: assert property (!setupOk && !reqReady |=> !reqReady)
		else $error("stream armed without a command setup");
	AST_LAST: assert property (reqValid && reqReady && reqLast |=> !reqReady && busy)
		else $error("last request byte did not start execution");
	AST_HOLD: assert property (rspValid && !rspReady |=> rspValid && $stable(rspData))
		else $error("response byte changed while stalled");
	AST_IDLE: assert property (!busy |-> spiCsN && !spiClk && !sclOe && !sdaOe)
		else $error("bus lines active while idle");
	AST_SPI_MODE: assert property ($fell(spiCsN) |-> !spiClk [*8])
		else $error("serial clock too soon after select");
	AST_SCL_RATE: assert property (sclOe != sclOeQ_ff |-> sclGap_ff >= usb_bridge_pkg::Q_I2C_FAST - 10'h001)
		else $error("two-wire clock phase too short");
	AST_GPIO: assert property ($changed(gpioLineOut) |-> $past(busy))
		else $error("gpio lines changed outside a command");
	// main scenarios
	COV_ARM: cover property (setupOk ##1 reqReady);
	COV_RSP: cover property (rspValid && !rspReady ##1 rspValid && rspReady);
	COV_I2C: cover property ($rose(sclOe));
endmodule : usb_bridge_cmd_asserts

// [tb/bus_target_model.sv]
`timescale 1ns/100ps
module bus_target_model
#(
	parameter logic [6:0] TARGET_ID = 7'h50
)
(
	// two-wire levels and data pull-down
	input  wire logic        scl,
	input  wire logic        sda,
	output logic             pullSda,
	// serial port lines
	input  wire logic        spiClk,
	input  wire logic        spiMosi,
	input  wire logic        spiCsN,
	output logic             spiMiso,
	output logic      [31:0] spiRx
);
	logic [7:0] mem [256];
	logic [7:0] sh   = 8'h00;
	logic [7:0] ptr  = 8'h00;
	logic [7:0] rep  = 8'hC0;
	logic       act  = 1'b0;
	logic       rd   = 1'b0;
	logic       nack = 1'b0;
	int         bitN = 0;
	int         byteN = 0;
	int         sBit = 0;
	// released lines at start
	initial
	begin
		pullSda = 1'b0;
		spiMiso = 1'b0;
		spiRx = 32'h0000_0000;
	end
	// start or repeated start restarts the frame, pointer kept
	always @(negedge sda)
		if (scl === 1'b1)
		begin
			act = 1'b1;
			rd = 1'b0;
			nack = 1'b0;
			bitN = -1;
			byteN = 0;
		end
	// stop frees the data line
	always @(posedge sda)
		if (scl === 1'b1)
		begin
			act = 1'b0;
			pullSda = 1'b0;
		end
	// shift in, or take the controller's acknowledge
	always @(posedge scl)
		if (act && rd && bitN == 8)
			nack = sda;
		else if (act && !rd && bitN < 8)
			sh = {sh[6:0], sda};
	// count bits, acknowledge, present read data
	always @(negedge scl)
		if (act)
		begin
			bitN = bitN + 1;
			pullSda = 1'b0;
			if (bitN == 8 && !rd)
			begin
				if (byteN == 0)
					{act, rd} = {sh[7:1] == TARGET_ID, sh[0]};
				else if (byteN == 1)
					ptr = sh;
				else
					mem[ptr++] = sh;
				pullSda = act;
			end
			if (bitN == 9)
			begin
				bitN = 0;
				byteN = byteN + 1;
				if (rd)
					sh = mem[ptr++];
			end
			if (rd && !nack && bitN < 8)
				pullSda = !sh[7 - bitN];
		end
	// reply byte k is C0 plus k, first bit ready at select
	always @(negedge spiCsN)
	begin
		sBit = 0;
		rep = 8'hC0;
		spiMiso = rep[7];
	end
	always @(posedge spiClk)
		if (!spiCsN)
		begin
			spiRx = {spiRx[30:0], spiMosi};
			sBit = sBit + 1;
		end
	always @(negedge spiClk)
		if (!spiCsN)
		begin
			if (sBit == 8)
				{sBit, rep} = {32'h0000_0000, rep + 8'h01};
			spiMiso = rep[7 - sBit];
		end
	// deselected line floats: show the inverse of the last bit
	always @(posedge spiCsN)
		spiMiso = !spiMiso;
endmodule : bus_target_model

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
	logic        clk          = 1'b0;
	logic        rst          = 1'b1;
	logic        setupValid   = 1'b0;
	logic [7:0]  setupType    = 8'h00;
	logic [7:0]  setupRequest = 8'h00;
	logic [15:0] setupIndex   = 16'h0000;
	logic        reqValid     = 1'b0;
	logic [7:0]  reqData      = 8'h00;
	logic        reqLast      = 1'b0;
	logic        rspReady     = 1'b0;
	logic [6:0]  gpioLineIn   = 7'h00;
	logic        reqReady, rspValid, rspLast, sclOe, sdaOe, pullSda, sclWire, sdaWire;
	logic        spiClk, spiMosi, spiMiso, spiCsN, busy;
	logic [7:0]  rspData;
	logic [6:0]  gpioLineOut;
	logic [31:0] spiRx;
	logic [7:0]  req [$];
	logic [7:0]  exp [$];
	int          numErrors    = 0;
	int          checkCount   = 0;
	// open-drain wires with pull-ups
	assign sclWire = !sclOe;
	assign sdaWire = !(sdaOe || pullSda);
	initial
		forever #2 clk = !clk;
	usb_bridge_cmd i_dut
	(
		.clk, .rst, .setupValid, .setupType, .setupRequest, .setupIndex, .reqValid, .reqData, .reqLast, .reqReady,
		.rspValid, .rspData, .rspLast, .rspReady, .sclIn(sclWire), .sclOut(), .sclOe, .sdaIn(sdaWire), .sdaOut(),
		.sdaOe, .spiClk, .spiMosi, .spiMiso, .spiCsN, .gpioLineIn, .gpioLineOut, .busy
	);
	bus_target_model i_tgt
	(
		.scl(sclWire), .sda(sdaWire), .pullSda, .spiClk, .spiMosi, .spiCsN, .spiMiso, .spiRx
	);
	// compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		checkCount++;
		if (seen !== want)
		begin
			numErrors++;
			$display("CHECK FAILED %s expected %h seen %h", what, want, seen);
		end
	endtask : check
	// counts and verdict
	task automatic conclude;
		$display("checks %0d mismatches %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	// a spent wait bound ends the run
	task automatic limit(input int t, input int n);
		if (t >= n)
		begin
			check("wait bound", 32'h0000_0000, 32'h0000_0001);
			conclude();
		end
	endtask : limit
	// setup stage, then req as one packet
	task automatic send(input logic [7:0] kind);
		int t;
		setupValid <= 1'b1;
		setupType <= kind;
		setupRequest <= usb_bridge_pkg::SETUP_REQUEST;
		setupIndex <= usb_bridge_pkg::SETUP_INDEX;
		@(posedge clk);
		setupValid <= 1'b0;
		foreach (req[i])
		begin
			reqValid <= 1'b1;
			reqData <= req[i];
			reqLast <= (i == req.size() - 1);
			t = 0;
			do
				@(posedge clk);
			while (reqReady !== 1'b1 && ++t < 50);
			limit(t, 50);
		end
		reqValid <= 1'b0;
		reqLast <= 1'b0;
	endtask : send
	// take each response byte after a one-cycle stall
	task automatic collect;
		int t;
		foreach (exp[i])
		begin
			t = 0;
			do
				@(posedge clk);
			while (rspValid !== 1'b1 && ++t < 40000);
			limit(t, 40000);
			@(posedge clk);
			check("response byte", 32'(rspData), 32'(exp[i]));
			check("response last", 32'(rspLast), 32'(i == exp.size() - 1));
			rspReady <= 1'b1;
			@(posedge clk);
			rspReady <= 1'b0;
		end
	endtask : collect
	task automatic run(input string name);
		send(usb_bridge_pkg::SETUP_TYPE);
		collect();
		$display("test %s done", name);
	endtask : run
	// data stays within 60 bytes per request
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		req = {};
		send(8'hA1);
		repeat (3) @(posedge clk);
		check("stream armed", 32'(reqReady), 32'h0000_0000);
		$display("test refused_setup done");
		req = {8'h13, 8'hA0, 8'h02, 8'h05, 8'hAA, 8'h55};
		exp = {8'h93, 8'hA0, 8'h02, 8'h05, 8'hAA, 8'h55};
		run("bad_code");
		req = {8'h10, 8'h00, 8'h3D, 8'h00};
		exp = {8'h90, 8'h00, 8'h3D, 8'h00};
		run("too_long");
		req = {8'h18, 8'h00, 8'h01, 8'h00, 8'h40};
		exp = {8'h38, 8'h00, 8'h01, 8'h00, 8'h40};
		run("gpio_write");
		check("gpio out", 32'(gpioLineOut), 32'h0000_0040);
		gpioLineIn <= 7'h2A;
		req = {8'h08, 8'h00, 8'h01, 8'h00};
		exp = {8'h28, 8'h00, 8'h01, 8'h00, 8'h2A};
		run("gpio_read");
		req = {8'h08, 8'h00, 8'h02, 8'h00};
		exp = {8'h88, 8'h00, 8'h02, 8'h00};
		run("gpio_bad_len");
		req = {8'h14, 8'h10, 8'h02, 8'hE0, 8'hAA, 8'h55};
		exp = {8'h34, 8'hC0, 8'h02, 8'hC1, 8'hAA, 8'h55};
		run("spi16_write");
		check("spi sent", spiRx, 32'h10E0_AA55);
		req = {8'h00, 8'hA0, 8'h02, 8'h05};
		exp = {8'h20, 8'hA0, 8'h02, 8'hC0, 8'hC1, 8'hC2};
		run("spi8_read");
		check("spi sent", 32'(spiRx[23:0]), 32'h0005_0000);
		req = {8'h10, 8'hA0, 8'h02, 8'h05, 8'hAA, 8'h55};
		exp = {8'h30, 8'hA0, 8'h02, 8'hC0, 8'hAA, 8'h55};
		run("spi8_write");
		check("spi sent", 32'(spiRx[23:0]), 32'h0005_AA55);
		req = {8'h12, 8'hA0, 8'h01, 8'h05, 8'hAA};
		exp = {8'h32, 8'hA0, 8'h01, 8'h05, 8'hAA};
		run("i2c_fast_write");
		req = {8'h02, 8'hA0, 8'h01, 8'h05};
		exp = {8'h22, 8'hA0, 8'h01, 8'h05, 8'hAA};
		run("i2c_fast_read");
		req = {8'h11, 8'hB0, 8'h01, 8'h05, 8'hAA};
		exp = {8'h51, 8'hB0, 8'h01, 8'h05, 8'hAA};
		run("i2c_100k_select_nack");
		conclude();
	end
endmodule : tb
bind usb_bridge_cmd usb_bridge_cmd_asserts i_chk
(
	.clk, .rst, .setupValid, .setupType, .setupRequest, .setupIndex, .reqValid, .reqLast, .reqReady,
	.rspValid, .rspData, .rspReady, .sclOe, .sdaOe, .spiClk, .spiCsN, .gpioLineOut, .busy
);
